// file: rtl/pcsep_pkg.sv
package pcsep_pkg;
    // Configuration dword byte offsets
    localparam logic [7:0] OFS_IDENTITY = 8'h00;
    localparam logic [7:0] OFS_CMDSTAT = 8'h04;
    localparam logic [7:0] OFS_CLASSREV = 8'h08;
    localparam logic [7:0] OFS_HDRLAT = 8'h0C;
    localparam logic [7:0] OFS_BAR0 = 8'h10;
    localparam logic [7:0] OFS_SUBSYS = 8'h2C;
    localparam logic [7:0] OFS_INTGNT = 8'h3C;
    localparam logic [7:0] OFS_TIMEOUT = 8'h40;
    localparam logic [7:0] OFS_USER = 8'h44;
    // EEPROM word addresses
    localparam int EEP_ADDR_W = 6;
    localparam int EEP_DATA_W = 16;
    localparam logic [5:0] WADDR_VENDOR = 6'h00;
    localparam logic [5:0] WADDR_DEVICE = 6'h01;
    localparam logic [5:0] WADDR_REV_CLASS = 6'h04;
    localparam logic [5:0] WADDR_CLASS_HI = 6'h05;
    localparam logic [5:0] WADDR_BIST_HDR = 6'h07;
    localparam logic [5:0] WADDR_SUBSYS_LO = 6'h16;
    localparam logic [5:0] WADDR_SUBSYS_HI = 6'h17;
    localparam logic [5:0] WADDR_INT_PIN = 6'h1E;
    localparam logic [5:0] WADDR_GNT_LAT = 6'h1F;
    localparam logic [5:0] WADDR_USER_LO = 6'h22;
    localparam logic [5:0] WADDR_USER_HI = 6'h23;
    localparam logic [3:0] PRELOAD_LAST = 4'hA;
    // Reset values and write masks
    localparam logic [7:0] RST_REVISION = 8'h01;
    localparam logic [23:0] RST_CLASS = 24'h038000;
    localparam logic [15:0] STATUS_FIXED = 16'h0200;
    localparam logic [31:0] CMD_WR_MASK = 32'h00000357;
    localparam logic [31:0] HDR_WR_MASK = 32'h0000FCFF;
    localparam logic [31:0] INT_WR_MASK = 32'h000000FF;
    localparam logic [31:0] TIMEOUT_WR_MASK = 32'h0000FFFF;
    localparam int CMD_BUS_MASTER_BIT = 2;
    localparam int CMD_MEM_ENABLE_BIT = 1;
    // Serial EEPROM read framing
    localparam logic [2:0] EEP_READ_OP = 3'h6;
    localparam logic [3:0] EEP_CMD_LAST = 4'h8;
    localparam logic [3:0] EEP_DATA_LAST = 4'hF;
endpackage : pcsep_pkg

// file: rtl/pcsep_preload_if.sv
`timescale 1ns/100ps
interface pcsep_preload_if;
    logic reqTgl;
    logic [pcsep_pkg::EEP_ADDR_W-1:0] wordAddr;
    logic ackTgl;
    logic [pcsep_pkg::EEP_DATA_W-1:0] wordData;
    modport core (output reqTgl, output wordAddr, input ackTgl, input wordData);
    modport link (input reqTgl, input wordAddr, output ackTgl, output wordData);
endinterface : pcsep_preload_if

// file: rtl/pcsep_eeprom_reader.sv
`timescale 1ns/100ps
module pcsep_eeprom_reader (
    // Clock and reset
    input wire logic clk_link,
    input wire logic arst_n,
    // Word request crossing
    pcsep_preload_if.link link,
    // Serial EEPROM pins
    output logic eepSel,
    output logic eepDataOut,
    input wire logic eepDataIn
);
    typedef enum logic [3:0] {
        RD_IDLE = 4'b0001,
        RD_SEND = 4'b0010,
        RD_RECV = 4'b0100,
        RD_DONE = 4'b1000
    } pcsep_rd_e;

    pcsep_rd_e rdState_r;
    logic rstSync1_r, rstSync2_r;
    logic reqSync1_r, reqSync2_r, reqSeen_r;
    logic reqEvent;
    logic [3:0] bitCnt_r;
    logic [7:0] txShift_r;
    logic [15:0] rxShift_r;
    logic [15:0] wordData_r;
    logic ackTgl_r;
    logic eepSel_r, eepDataOut_r;

    // Reset release synchronised to the link clock
    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end

    // Request toggle crossing
    always_ff @(posedge clk_link or negedge rstSync2_r) begin
        if (!rstSync2_r) begin
            reqSync1_r <= 1'b0;
            reqSync2_r <= 1'b0;
            reqSeen_r <= 1'b0;
        end else begin
            reqSync1_r <= link.reqTgl;
            reqSync2_r <= reqSync1_r;
            reqSeen_r <= reqSync2_r;
        end
    end
    assign reqEvent = reqSync2_r ^ reqSeen_r;

    // Read frame: start, opcode, word address, then sixteen data bits
    always_ff @(posedge clk_link or negedge rstSync2_r) begin
        if (!rstSync2_r) begin
            rdState_r <= RD_IDLE;
            bitCnt_r <= 4'h0;
            txShift_r <= 8'h00;
            rxShift_r <= 16'h0000;
            wordData_r <= 16'h0000;
            ackTgl_r <= 1'b0;
            eepSel_r <= 1'b0;
            eepDataOut_r <= 1'b0;
        end else begin
            case (rdState_r)
                RD_IDLE: begin
                    if (reqEvent) begin
                        {eepDataOut_r, txShift_r} <= {pcsep_pkg::EEP_READ_OP, link.wordAddr};
                        eepSel_r <= 1'b1;
                        bitCnt_r <= 4'h0;
                        rdState_r <= RD_SEND;
                    end
                end
                RD_SEND: begin
                    eepDataOut_r <= txShift_r[7];
                    txShift_r <= {txShift_r[6:0], 1'b0};
                    bitCnt_r <= bitCnt_r + 4'h1;
                    if (bitCnt_r == pcsep_pkg::EEP_CMD_LAST) begin
                        eepDataOut_r <= 1'b0;
                        bitCnt_r <= 4'h0;
                        rdState_r <= RD_RECV;
                    end
                end
                RD_RECV: begin
                    rxShift_r <= {rxShift_r[14:0], eepDataIn};
                    bitCnt_r <= bitCnt_r + 4'h1;
                    if (bitCnt_r == pcsep_pkg::EEP_DATA_LAST) begin
                        rdState_r <= RD_DONE;
                    end
                end
                RD_DONE: begin
                    wordData_r <= rxShift_r;
                    ackTgl_r <= ~ackTgl_r;
                    eepSel_r <= 1'b0;
                    rdState_r <= RD_IDLE;
                end
                default: begin
                    rdState_r <= RD_IDLE;
                    eepSel_r <= 1'b0;
                end
            endcase
        end
    end

    assign link.ackTgl = ackTgl_r;
    assign link.wordData = wordData_r;
    assign eepSel = eepSel_r;
    assign eepDataOut = eepDataOut_r;

    frame_length_a: assert property (@(posedge clk_link) disable iff (!rstSync2_r)
        (rdState_r == RD_IDLE && reqEvent) |-> ##26 (rdState_r == RD_DONE))
        else $error("word read frame not 26 link cycles");
    select_held_a: assert property (@(posedge clk_link) disable iff (!rstSync2_r)
        (rdState_r == RD_SEND || rdState_r == RD_RECV) |-> eepSel_r)
        else $error("select dropped inside frame");
    frame_cover_c: cover property (@(posedge clk_link) disable iff (!rstSync2_r)
        rdState_r == RD_DONE);
endmodule : pcsep_eeprom_reader

// file: rtl/pcsep_config_space.sv
`timescale 1ns/100ps
// What this block does
// - Identity and other device-specific fields can be filled from the EEPROM.
// - Command register changes only by configuration writes, never from EEPROM.
// - A 32-bit user register at offset 44 is loaded from EEPROM.
// - Loadable registers fetched as 16-bit EEPROM words, two per register except one for offset 0C.
// - Fixed mapping of EEPROM word addresses onto configuration offsets.
// - Plain read-only fields return fixed values, ignore writes and preload.
// - EEPROM-loaded read-only fields return preload value and ignore writes.
// - Read/write fields follow configuration writes, untouched by preload.
// - Vendor identity in bits 15-0 of offset 00, with reset default.
// - Device identity in upper half of offset 00, with reset default.
module pcsep_config_space #(
    parameter logic [15:0] VENDOR_DEFAULT = 16'hA5A5,
    parameter logic [15:0] DEVICE_DEFAULT = 16'h5A5A,
    parameter logic [31:0] BAR0_WR_MASK = 32'hFF000000
) (
    // Clocks and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_link,
    // Configuration cycle port
    input wire logic cfgReq,
    input wire logic cfgWrite,
    input wire logic [7:0] cfgAddr,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWrData,
    output logic cfgAck,
    output logic cfgRetry,
    output logic [31:0] cfgRdData,
    // Serial EEPROM pins
    output logic eepSel,
    output logic eepDataOut,
    input wire logic eepDataIn,
    // Device status
    output logic preloadDone,
    output logic busMasterEn,
    output logic memAccessEn
);
    typedef enum logic [2:0] {
        LD_ISSUE = 3'b001,
        LD_WAIT = 3'b010,
        LD_READY = 3'b100
    } pcsep_ld_e;

    pcsep_preload_if preload ();

    pcsep_ld_e ldState_r;
    logic [3:0] ldIdx_r;
    logic reqTgl_r;
    logic [5:0] wordAddr_r;
    logic ackSync1_r, ackSync2_r, ackSeen_r;
    logic ackEvent, loadStore;
    logic cfgReady, cfgHit, cfgWrHit;
    logic [7:0] cfgDword;
    logic [31:0] readValue;
    logic [15:0] vendor_r, device_r, bistHdr_r;
    logic [7:0] revision_r, intPin_r;
    logic [23:0] class_r;
    logic [15:0] gntLat_r;
    logic [31:0] subsys_r, user_r;
    logic [31:0] cmdWord_r, hdrWord_r, bar0_r, intWord_r, timeoutWord_r;
    logic cfgAck_r, cfgRetry_r, preloadDone_r, busMasterEn_r, memAccessEn_r;
    logic [31:0] cfgRdData_r;

    function automatic logic [5:0] preload_addr(input logic [3:0] idx);
        case (idx)
            4'h0: preload_addr = pcsep_pkg::WADDR_VENDOR;
            4'h1: preload_addr = pcsep_pkg::WADDR_DEVICE;
            4'h2: preload_addr = pcsep_pkg::WADDR_REV_CLASS;
            4'h3: preload_addr = pcsep_pkg::WADDR_CLASS_HI;
            4'h4: preload_addr = pcsep_pkg::WADDR_BIST_HDR;
            4'h5: preload_addr = pcsep_pkg::WADDR_SUBSYS_LO;
            4'h6: preload_addr = pcsep_pkg::WADDR_SUBSYS_HI;
            4'h7: preload_addr = pcsep_pkg::WADDR_INT_PIN;
            4'h8: preload_addr = pcsep_pkg::WADDR_GNT_LAT;
            4'h9: preload_addr = pcsep_pkg::WADDR_USER_LO;
            4'hA: preload_addr = pcsep_pkg::WADDR_USER_HI;
            default: preload_addr = pcsep_pkg::WADDR_VENDOR;
        endcase
    endfunction : preload_addr

    function automatic logic [31:0] be_merge(input logic [31:0] oldV, input logic [31:0] newV,
                                             input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] res;
        res = oldV;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = newV[8*i +: 8];
            end
        end
        return res & mask;
    endfunction : be_merge

    pcsep_eeprom_reader u_reader (
        .clk_link(clk_link),
        .arst_n(arst_n),
        .link(preload.link),
        .eepSel(eepSel),
        .eepDataOut(eepDataOut),
        .eepDataIn(eepDataIn)
    );

    assign preload.reqTgl = reqTgl_r;
    assign preload.wordAddr = wordAddr_r;

    // Acknowledge toggle crossing
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ackSync1_r <= 1'b0;
            ackSync2_r <= 1'b0;
            ackSeen_r <= 1'b0;
        end else begin
            ackSync1_r <= preload.ackTgl;
            ackSync2_r <= ackSync1_r;
            ackSeen_r <= ackSync2_r;
        end
    end
    assign ackEvent = ackSync2_r ^ ackSeen_r;
    assign loadStore = (ldState_r == LD_WAIT) && ackEvent;

    // Preload sequencer, one word at a time
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ldState_r <= LD_ISSUE;
            ldIdx_r <= 4'h0;
            reqTgl_r <= 1'b0;
            wordAddr_r <= 6'h00;
        end else begin
            case (ldState_r)
                LD_ISSUE: begin
                    wordAddr_r <= preload_addr(ldIdx_r);
                    reqTgl_r <= ~reqTgl_r;
                    ldState_r <= LD_WAIT;
                end
                LD_WAIT: begin
                    if (ackEvent) begin
                        if (ldIdx_r == pcsep_pkg::PRELOAD_LAST) begin
                            ldState_r <= LD_READY;
                        end else begin
                            ldIdx_r <= ldIdx_r + 4'h1;
                            ldState_r <= LD_ISSUE;
                        end
                    end
                end
                LD_READY: begin
                    ldState_r <= LD_READY;
                end
                default: begin
                    ldState_r <= LD_ISSUE;
                end
            endcase
        end
    end

    // EEPROM-loaded read-only fields
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            vendor_r <= VENDOR_DEFAULT;
            device_r <= DEVICE_DEFAULT;
            revision_r <= pcsep_pkg::RST_REVISION;
            class_r <= pcsep_pkg::RST_CLASS;
            bistHdr_r <= 16'h0000;
            subsys_r <= 32'h00000000;
            intPin_r <= 8'h00;
            gntLat_r <= 16'h0000;
            user_r <= 32'h00000000;
        end else if (loadStore) begin
            case (wordAddr_r)
                pcsep_pkg::WADDR_VENDOR: vendor_r <= preload.wordData;
                pcsep_pkg::WADDR_DEVICE: device_r <= preload.wordData;
                pcsep_pkg::WADDR_REV_CLASS: begin
                    {class_r[7:0], revision_r} <= preload.wordData;
                end
                pcsep_pkg::WADDR_CLASS_HI: class_r[23:8] <= preload.wordData;
                pcsep_pkg::WADDR_BIST_HDR: bistHdr_r <= preload.wordData;
                pcsep_pkg::WADDR_SUBSYS_LO: subsys_r[15:0] <= preload.wordData;
                pcsep_pkg::WADDR_SUBSYS_HI: subsys_r[31:16] <= preload.wordData;
                pcsep_pkg::WADDR_INT_PIN: intPin_r <= preload.wordData[15:8];
                pcsep_pkg::WADDR_GNT_LAT: gntLat_r <= preload.wordData;
                pcsep_pkg::WADDR_USER_LO: user_r[15:0] <= preload.wordData;
                pcsep_pkg::WADDR_USER_HI: user_r[31:16] <= preload.wordData;
                default: begin
                end
            endcase
        end
    end

    assign cfgReady = (ldState_r == LD_READY);
    assign cfgHit = cfgReq && cfgReady;
    assign cfgWrHit = cfgHit && cfgWrite;
    assign cfgDword = {cfgAddr[7:2], 2'b00};

    // Read/write fields, changed only by configuration writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cmdWord_r <= 32'h00000000;
            hdrWord_r <= 32'h00000000;
            bar0_r <= 32'h00000000;
            intWord_r <= 32'h00000000;
            timeoutWord_r <= 32'h00000000;
        end else if (cfgWrHit) begin
            case (cfgDword)
                pcsep_pkg::OFS_CMDSTAT: begin
                    cmdWord_r <= be_merge(cmdWord_r, cfgWrData, cfgByteEn, pcsep_pkg::CMD_WR_MASK);
                end
                pcsep_pkg::OFS_HDRLAT: begin
                    hdrWord_r <= be_merge(hdrWord_r, cfgWrData, cfgByteEn, pcsep_pkg::HDR_WR_MASK);
                end
                pcsep_pkg::OFS_BAR0: begin
                    bar0_r <= be_merge(bar0_r, cfgWrData, cfgByteEn, BAR0_WR_MASK);
                end
                pcsep_pkg::OFS_INTGNT: begin
                    intWord_r <= be_merge(intWord_r, cfgWrData, cfgByteEn, pcsep_pkg::INT_WR_MASK);
                end
                pcsep_pkg::OFS_TIMEOUT: begin
                    timeoutWord_r <= be_merge(timeoutWord_r, cfgWrData, cfgByteEn,
                                              pcsep_pkg::TIMEOUT_WR_MASK);
                end
                default: begin
                end
            endcase
        end
    end

    // Configuration read multiplexer
    always_comb begin
        readValue = 32'h00000000;
        case (cfgDword)
            pcsep_pkg::OFS_IDENTITY: readValue = {device_r, vendor_r};
            pcsep_pkg::OFS_CMDSTAT: readValue = {pcsep_pkg::STATUS_FIXED, cmdWord_r[15:0]};
            pcsep_pkg::OFS_CLASSREV: readValue = {class_r, revision_r};
            pcsep_pkg::OFS_HDRLAT: readValue = {bistHdr_r, hdrWord_r[15:0]};
            pcsep_pkg::OFS_BAR0: readValue = bar0_r;
            pcsep_pkg::OFS_SUBSYS: readValue = subsys_r;
            pcsep_pkg::OFS_INTGNT: readValue = {gntLat_r, intPin_r, intWord_r[7:0]};
            pcsep_pkg::OFS_TIMEOUT: readValue = timeoutWord_r;
            pcsep_pkg::OFS_USER: readValue = user_r;
            default: readValue = 32'h00000000;
        endcase
    end

    // Answer to each configuration cycle, one cycle later
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfgAck_r <= 1'b0;
            cfgRetry_r <= 1'b0;
            cfgRdData_r <= 32'h00000000;
        end else begin
            cfgAck_r <= cfgHit;
            cfgRetry_r <= cfgReq && !cfgReady;
            cfgRdData_r <= (cfgHit && !cfgWrite) ? readValue : 32'h00000000;
        end
    end

    // Status outputs
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            preloadDone_r <= 1'b0;
            busMasterEn_r <= 1'b0;
            memAccessEn_r <= 1'b0;
        end else begin
            preloadDone_r <= cfgReady;
            busMasterEn_r <= cmdWord_r[pcsep_pkg::CMD_BUS_MASTER_BIT];
            memAccessEn_r <= cmdWord_r[pcsep_pkg::CMD_MEM_ENABLE_BIT];
        end
    end

    assign cfgAck = cfgAck_r;
    assign cfgRetry = cfgRetry_r;
    assign cfgRdData = cfgRdData_r;
    assign preloadDone = preloadDone_r;
    assign busMasterEn = busMasterEn_r;
    assign memAccessEn = memAccessEn_r;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    retry_while_load_a: assert property (cfgReq && !cfgReady |=> cfgRetry && !cfgAck)
        else $error("cycle not retried during preload");
    ack_when_ready_a: assert property (cfgReq && cfgReady |=> cfgAck && !cfgRetry)
        else $error("cycle not acknowledged after preload");
    reserved_zero_a: assert property (
        cfgHit && !cfgWrite && (cfgDword == 8'h14 || cfgDword == 8'h30 || cfgDword > 8'h44)
        |=> cfgRdData == 32'h00000000)
        else $error("reserved offset read nonzero");
    ident_ro_a: assert property (
        cfgWrHit && cfgDword == pcsep_pkg::OFS_IDENTITY |=> $stable({device_r, vendor_r}))
        else $error("identity changed by write");
    user_ro_a: assert property (
        cfgWrHit && cfgDword == pcsep_pkg::OFS_USER |=> $stable(user_r))
        else $error("user word changed by write");
    cmd_write_a: assert property (
        cfgWrHit && cfgDword == pcsep_pkg::OFS_CMDSTAT && cfgByteEn == 4'hF
        |=> cmdWord_r[15:0] == ($past(cfgWrData[15:0]) & 16'h0357))
        else $error("command write not stored");
    cmd_noload_a: assert property (loadStore && !cfgWrHit |=> $stable(cmdWord_r))
        else $error("command changed by preload");
    vendor_load_a: assert property (
        loadStore && wordAddr_r == pcsep_pkg::WADDR_VENDOR
        |=> vendor_r == $past(preload.wordData))
        else $error("vendor word not loaded");
    user_load_a: assert property (
        loadStore && wordAddr_r == pcsep_pkg::WADDR_USER_HI
        |=> user_r[31:16] == $past(preload.wordData) && $stable(user_r[15:0]))
        else $error("user upper half not loaded");
    status_fixed_a: assert property (
        cfgHit && !cfgWrite && cfgDword == pcsep_pkg::OFS_CMDSTAT
        |=> cfgRdData[31:16] == 16'h0200)
        else $error("fixed status bits wrong");
    ident_default_a: assert property (
        ldState_r == LD_ISSUE && ldIdx_r == 4'h0
        |-> vendor_r == VENDOR_DEFAULT && device_r == DEVICE_DEFAULT)
        else $error("identity default missing before preload");
    word_answer_a: assert property (
        ldState_r == LD_ISSUE |=> ldState_r == LD_WAIT ##[1:400] ackEvent)
        else $error("preload word not answered in time");
    enable_follow_a: assert property (
        busMasterEn_r == $past(cmdWord_r[2]) && memAccessEn_r == $past(cmdWord_r[1]))
        else $error("enable outputs do not follow command");

    preload_done_c: cover property ($rose(preloadDone_r));
    retry_seen_c: cover property (cfgRetry_r);
    user_read_c: cover property (cfgHit && !cfgWrite && cfgDword == pcsep_pkg::OFS_USER);
    cmd_enable_c: cover property (busMasterEn_r && memAccessEn_r);
endmodule : pcsep_config_space

// file: verification/pcsep_eeprom_model.sv
`timescale 1ns/100ps
module pcsep_eeprom_model (
    // Link side
    input wire logic clk_link,
    input wire logic eepSel,
    input wire logic eepDataOut,
    output logic eepDataIn
);
    logic [4:0] bitCnt = 5'h00;
    logic [8:0] cmdBits = 9'h000;
    logic [8:0] full;
    logic [15:0] word = 16'h0000;
    initial eepDataIn = 1'b0;
    function automatic logic [15:0] wordOf(input logic [5:0] a);
        return {a, 2'h3, ~a, 2'h1};
    endfunction : wordOf
    // Command capture, then 16 data bits MSB first
    always @(posedge clk_link) begin
        full = {cmdBits[7:0], eepDataOut};
        bitCnt <= eepSel ? bitCnt + 5'h01 : 5'h00;
        if (eepSel && bitCnt < 5'h09)
            cmdBits <= full;
        if (eepSel && bitCnt == 5'h08) begin
            word = (full[8:6] == 3'h6) ? wordOf(full[5:0]) : 16'h0000;
            eepDataIn <= word[15];
        end else if (eepSel && bitCnt > 5'h08 && bitCnt < 5'h18)
            eepDataIn <= word[5'h17 - bitCnt];
        else
            eepDataIn <= ~eepDataIn;
    end
endmodule : pcsep_eeprom_model

// file: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'b0;
    logic clkLink = 1'b0;
    logic arst_n = 1'b0;
    logic cfgReq = 1'b0;
    logic cfgWrite = 1'b0;
    logic [7:0] cfgAddr = 8'h00;
    logic [3:0] cfgByteEn = 4'h0;
    logic [31:0] cfgWrData = 32'h00000000;
    logic cfgAck, cfgRetry, preloadDone, busMasterEn, memAccessEn;
    logic eepSel, eepDataOut, eepDataIn, ackV, retryV;
    logic [31:0] cfgRdData, rdVal;
    int err_count = 0;
    int check_count = 0;
    always #5 clk_sys = ~clk_sys;
    always #32 clkLink = ~clkLink;
    pcsep_config_space i_pcsep_config_space (.clk_sys(clk_sys), .arst_n(arst_n),
        .clk_link(clkLink), .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
        .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgAck(cfgAck), .cfgRetry(cfgRetry),
        .cfgRdData(cfgRdData), .eepSel(eepSel), .eepDataOut(eepDataOut),
        .eepDataIn(eepDataIn), .preloadDone(preloadDone), .busMasterEn(busMasterEn),
        .memAccessEn(memAccessEn));
    pcsep_eeprom_model i_pcsep_eeprom_model (.clk_link(clkLink), .eepSel(eepSel),
        .eepDataOut(eepDataOut), .eepDataIn(eepDataIn));
    function automatic logic [31:0] pair(input logic [5:0] hi, input logic [5:0] lo);
        return {i_pcsep_eeprom_model.wordOf(hi), i_pcsep_eeprom_model.wordOf(lo)};
    endfunction : pair
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One configuration cycle, answer sampled in the following cycle
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        cfgReq = 1'b1;
        cfgWrite = wr;
        cfgAddr = a;
        cfgByteEn = be;
        cfgWrData = d;
        @(posedge clk_sys);
        #1;
        cfgReq = 1'b0;
        ackV = cfgAck;
        retryV = cfgRetry;
        rdVal = cfgRdData;
    endtask : cfg
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        cfg(1'b0, a, 4'h0, 32'h00000000);
        chk("ack", {31'h0, ackV}, 32'h1);
        chk(what, rdVal, exp);
    endtask : rd
    task automatic t_early();
        cfg(1'b0, pcsep_pkg::OFS_IDENTITY, 4'h0, 32'h00000000);
        chk("retry read", {31'h0, retryV}, 32'h1);
        chk("no ack in preload", {31'h0, ackV}, 32'h0);
        cfg(1'b1, pcsep_pkg::OFS_CMDSTAT, 4'hF, 32'hFFFFFFFF);
        chk("retry write", {31'h0, retryV}, 32'h1);
        for (int i = 0; i < 20000 && preloadDone !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("preload", {31'h0, preloadDone}, 32'h1);
        if (preloadDone !== 1'b1)
            close_out();
        $display("test early done");
    endtask : t_early
    task automatic t_load();
        rd("identity", pcsep_pkg::OFS_IDENTITY, pair(6'h01, 6'h00));
        rd("classrev", pcsep_pkg::OFS_CLASSREV, pair(6'h05, 6'h04));
        rd("hdr", pcsep_pkg::OFS_HDRLAT, {pair(6'h07, 6'h00)} & 32'hFFFF0000);
        rd("subsys", pcsep_pkg::OFS_SUBSYS, pair(6'h17, 6'h16));
        rd("intgnt", pcsep_pkg::OFS_INTGNT, pair(6'h1F, 6'h1E) & 32'hFFFFFF00);
        rd("user", pcsep_pkg::OFS_USER, pair(6'h23, 6'h22));
        rd("cmd", pcsep_pkg::OFS_CMDSTAT, 32'h02000000);
        $display("test load done");
    endtask : t_load
    task automatic t_ro();
        cfg(1'b1, pcsep_pkg::OFS_IDENTITY, 4'hF, 32'h00000000);
        cfg(1'b1, pcsep_pkg::OFS_USER, 4'hF, 32'h00000000);
        cfg(1'b1, 8'h14, 4'hF, 32'hFFFFFFFF);
        rd("identity ro", pcsep_pkg::OFS_IDENTITY, pair(6'h01, 6'h00));
        rd("user ro", pcsep_pkg::OFS_USER, pair(6'h23, 6'h22));
        rd("reserved", 8'h14, 32'h00000000);
        $display("test readonly done");
    endtask : t_ro
    task automatic t_rw();
        cfg(1'b1, pcsep_pkg::OFS_CMDSTAT, 4'hF, 32'hFFFFFFFF);
        cfg(1'b1, pcsep_pkg::OFS_HDRLAT, 4'hF, 32'hFFFFFFFF);
        cfg(1'b1, pcsep_pkg::OFS_BAR0, 4'hF, 32'hFFFFFFFF);
        cfg(1'b1, pcsep_pkg::OFS_INTGNT, 4'hF, 32'hFFFFFFFF);
        cfg(1'b1, pcsep_pkg::OFS_TIMEOUT, 4'h1, 32'hFFFFFFFF);
        rd("cmd rw", pcsep_pkg::OFS_CMDSTAT, 32'h02000357);
        rd("hdr rw", pcsep_pkg::OFS_HDRLAT, (pair(6'h07, 6'h00) & 32'hFFFF0000) | 32'hFCFF);
        rd("bar0", pcsep_pkg::OFS_BAR0, 32'hFF000000);
        rd("int line", pcsep_pkg::OFS_INTGNT, (pair(6'h1F, 6'h1E) & 32'hFFFFFF00) | 32'hFF);
        rd("timeout", pcsep_pkg::OFS_TIMEOUT, 32'h000000FF);
        chk("bus master", {31'h0, busMasterEn}, 32'h1);
        chk("mem enable", {31'h0, memAccessEn}, 32'h1);
        cfg(1'b1, pcsep_pkg::OFS_CMDSTAT, 4'hF, 32'h00000000);
        @(posedge clk_sys);
        #1;
        chk("bus master off", {31'h0, busMasterEn}, 32'h0);
        chk("mem enable off", {31'h0, memAccessEn}, 32'h0);
        $display("test readwrite done");
    endtask : t_rw
    initial begin
        repeat (6) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        t_early();
        t_load();
        t_ro();
        t_rw();
        close_out();
    end
endmodule : testbench
